// [logic/half_bridge_gate_protection.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE1: Boot-supply lockout only affects high side, never the low side.
// RULE2: High side refused for whole pulse if upper boot lockout at rise.
// RULE3: Once high side on, watch only lower boot lockout until pulse ends.
// RULE4: Lower boot lockout while on turns high side off for rest of pulse.
// RULE5: Every new command pulse reattempts turn-on despite earlier trips.
// RULE6: Over-current while on turns that side off for rest of its pulse.
// RULE7: Separate over-current flags for low and high side.
// RULE8: Over-current never drives the fault output.
// RULE9: Low-side over-current turn-off requests artificial sense ramp.
// RULE10: Over-temperature holds both switches off regardless of commands.
// RULE11: Fault asserts only and always during over-temperature.
// RULE12: Over-temperature protection active only while aux supply above POR.
// RULE13: Fault output is active low open drain.
// RULE14: Mode high is active: switches follow commands under protection.
// RULE15: Mode low is standby: commands ignored, switches off, low-power flag.
// RULE16: Both commands high at interlock enable gives low side control.
// RULE17: Controlling command keeps control while high; only it passes.
// RULE18: High side turns on only if no universal block at its rising edge.
// RULE19: Sense ramp request holds until low-side command goes low.
// RULE20: Commands, mode and flags pass two-stage synchronisers first.
// RULE21: Per-pulse latches clear when their command returns low.
module half_bridge_gate_protection
  import gate_protect_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      reset_n,
  input  wire cmd_type   cmd_in,
  input  wire flags_type flags_in,
  output logic           low_gate_en,
  output logic           high_gate_en,
  output logic           fault_n_out,
  output logic           fault_n_oe,
  output logic           cs_ramp_req,
  output logic           standby_lowpower
);

  logic         rst_meta_q;
  logic         rst_n_q;
  cmd_type      cmd_s;
  flags_type    flg_s;
  logic         hs_cmd_prev_q;
  logic         univ_block;
  logic         ot_active;
  logic         il_low;
  logic         il_high;
  logic         ls_trip_q;
  logic         ls_trip_now;
  logic         hs_rise;
  owner_type    owner_q;
  owner_type    owner_d;
  hs_state_type hs_q;
  hs_state_type hs_d;

  // Reset release through two flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Synchronise all asynchronous inputs
  flag_sync #(.WIDTH($bits(cmd_type))) u_cmd_sync (      // RULE20
    .clock    (clock),
    .rst_n    (rst_n_q),
    .async_in (cmd_in),
    .sync_out (cmd_s)
  );

  flag_sync #(.WIDTH($bits(flags_type))) u_flag_sync (   // RULE20
    .clock    (clock),
    .rst_n    (rst_n_q),
    .async_in (flags_in),
    .sync_out (flg_s)
  );

  // Over-temperature only counts once aux has passed its POR level
  assign ot_active  = flg_s.over_temp & flg_s.aux_por_ok;           // RULE12
  // Boot lockout deliberately absent here so the low side never sees it
  assign univ_block = ~cmd_s.mode_active | flg_s.aux_uv | ot_active; // RULE1

  // Interlock ownership; cleared while disabled
  always_comb begin
    owner_d = owner_q;
    if (univ_block) begin
      owner_d = OWN_NONE;
    end else begin
      case (owner_q)
        OWN_LOW: begin
          if (!cmd_s.low_side_cmd) owner_d = OWN_NONE;            // RULE17
        end
        OWN_HIGH: begin
          if (!cmd_s.high_side_cmd) owner_d = OWN_NONE;           // RULE17
        end
        default: begin
          if (cmd_s.low_side_cmd) owner_d = OWN_LOW;              // RULE16
          else if (cmd_s.high_side_cmd) owner_d = OWN_HIGH;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      owner_q <= OWN_NONE;
    end else begin
      owner_q <= owner_d;
    end
  end

  // Interlock outputs pass only the owner's command
  assign il_low  = (owner_q == OWN_LOW)  & cmd_s.low_side_cmd;    // RULE17
  assign il_high = (owner_q == OWN_HIGH) & cmd_s.high_side_cmd;   // RULE17

  // Previous synchronised high command, for its rising edge
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hs_cmd_prev_q <= 1'b0;
    end else begin
      hs_cmd_prev_q <= cmd_s.high_side_cmd;
    end
  end

  // Resets to the pin's idle low level, so no false edge after reset
  assign hs_rise = cmd_s.high_side_cmd & ~hs_cmd_prev_q;

  // High-side per-pulse sequence; decision made once at the rising edge
  // so a partial turn-on cannot happen later in the pulse
  always_comb begin
    hs_d = hs_q;
    case (hs_q)
      HS_IDLE: begin
        if (hs_rise) begin
          if (univ_block || flg_s.boot_upper_uv)                 // RULE2
            hs_d = HS_BLOCKED;                                     // RULE18
          else if (owner_d == OWN_HIGH)
            hs_d = HS_ON;                                          // RULE5
          else
            hs_d = HS_BLOCKED;
        end
      end
      HS_ON: begin
        if (!cmd_s.high_side_cmd) hs_d = HS_IDLE;                 // RULE21
        else if (univ_block) hs_d = HS_TRIPPED;                   // RULE10
        else if (flg_s.boot_lower_uv) hs_d = HS_TRIPPED;          // RULE3
        else if (flg_s.ocp_high) hs_d = HS_TRIPPED;               // RULE6
      end
      default: begin
        if (!cmd_s.high_side_cmd) hs_d = HS_IDLE;                 // RULE21
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hs_q <= HS_IDLE;
    end else begin
      hs_q <= hs_d;
    end
  end

  // Low-side trip this cycle: switch on and its own over-current flag up
  assign ls_trip_now = low_gate_en & flg_s.ocp_low;                 // RULE7

  // Low-side over-current latch, cleared by the command falling.
  // The pulse end wins over a trip in the same cycle: nothing to hold.
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ls_trip_q <= 1'b0;
    end else if (!cmd_s.low_side_cmd) begin
      ls_trip_q <= 1'b0;                                            // RULE21
    end else if (ls_trip_now) begin
      ls_trip_q <= 1'b1;                                            // RULE6
    end
  end

  // Low gate; the trip term cuts it on the edge that sets the latch
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      low_gate_en <= GATE_RST;
    end else begin
      low_gate_en <= il_low & ~univ_block                           // RULE14
                     & ~ls_trip_q & ~ls_trip_now;                   // RULE6
    end
  end

  // High gate; tripped high side held off until the pulse ends
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      high_gate_en <= GATE_RST;
    end else begin
      high_gate_en <= (hs_d == HS_ON) & il_high;                    // RULE4
    end
  end

  // Sense ramp request after low-side trip, until command drops
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_ramp_req <= RAMP_RST;
    end else if (!cmd_s.low_side_cmd) begin
      cs_ramp_req <= 1'b0;                                          // RULE19
    end else if (ls_trip_now) begin
      cs_ramp_req <= 1'b1;                                          // RULE9
    end
  end

  // Fault pin: open drain, low only for over-temperature
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_n_out <= FAULT_RST;
      fault_n_oe  <= OE_RST;
    end else begin
      fault_n_out <= FAULT_RST;                                     // RULE13
      // Over-current flags never reach the enable
      fault_n_oe  <= ot_active;                               // RULE8 RULE11
    end
  end

  // Standby indication follows the synchronised mode input
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      standby_lowpower <= STANDBY_RST;
    end else begin
      standby_lowpower <= ~cmd_s.mode_active;                       // RULE15
    end
  end

endmodule

// [logic/gate_protect_pkg.sv]
package gate_protect_pkg;

  // Synchroniser depth for command, mode and comparator flags
  localparam int SYNC_STAGES = 2;

  // Reset values of the driven outputs
  localparam logic GATE_RST    = 1'b0;
  localparam logic FAULT_RST   = 1'b0;
  localparam logic OE_RST      = 1'b0;
  localparam logic RAMP_RST    = 1'b0;
  localparam logic STANDBY_RST = 1'b0;

  // Raw comparator flags, all active high
  typedef struct packed {
    logic boot_upper_uv;
    logic boot_lower_uv;
    logic aux_uv;
    logic aux_por_ok;
    logic ocp_low;
    logic ocp_high;
    logic over_temp;
  } flags_type;

  // Commands and mode
  typedef struct packed {
    logic mode_active;
    logic low_side_cmd;
    logic high_side_cmd;
  } cmd_type;

  // Interlock owner
  typedef enum logic [2:0] {
    OWN_NONE = 3'b001,
    OWN_LOW  = 3'b010,
    OWN_HIGH = 3'b100
  } owner_type;

  // High-side per-pulse state
  typedef enum logic [3:0] {
    HS_IDLE    = 4'b0001,
    HS_ON      = 4'b0010,
    HS_BLOCKED = 4'b0100,
    HS_TRIPPED = 4'b1000
  } hs_state_type;

endpackage

// [logic/flag_sync.sv]
`timescale 1ns/1ps
module flag_sync
  import gate_protect_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [tb/gate_protect_sva.sv]
`timescale 1ns/1ps
module gate_protect_sva
  import gate_protect_pkg::*;
(
  input wire logic      clock,
  input wire logic      reset_n,
  input wire cmd_type   cmd_in,
  input wire flags_type flags_in,
  input wire logic      low_gate_en,
  input wire logic      high_gate_en,
  input wire logic      fault_n_out,
  input wire logic      fault_n_oe,
  input wire logic      cs_ramp_req,
  input wire logic      standby_lowpower
);
  // Outputs trail inputs by three edges, gate turn-on by four; skip reset and sync fill
  logic [2:0] age_q;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n || age_q != 3'h7);
  sequence s_high_off;
    ##3 !high_gate_en [*4];
  endsequence
  a_fault_only_ot: assert property (
    fault_n_oe == $past(flags_in.over_temp && flags_in.aux_por_ok, 3))
    else $error("bad fault enable");
  a_fault_pulls_low: assert property (fault_n_out == 1'h0)
    else $error("fault data not low");
  a_ot_all_off: assert property (
    $past(flags_in.over_temp && flags_in.aux_por_ok, 3) |->
    !low_gate_en && !high_gate_en) else $error("gate on in over temp");
  a_standby_off: assert property (
    standby_lowpower == !$past(cmd_in.mode_active, 3) &&
    !(standby_lowpower && (low_gate_en || high_gate_en)))
    else $error("bad standby");
  a_no_overlap: assert property (!(low_gate_en && high_gate_en))
    else $error("both gates on");
  a_ramp_cause: assert property (
    $rose(cs_ramp_req) |-> $past(flags_in.ocp_low, 3) && !low_gate_en)
    else $error("ramp without trip");
  a_ramp_hold: assert property (
    cs_ramp_req && $past(cmd_in.low_side_cmd, 2) |=> cs_ramp_req)
    else $error("ramp dropped early");
  a_high_trip: assert property (
    high_gate_en && (flags_in.ocp_high || flags_in.boot_lower_uv) |->
    s_high_off) else $error("high side not tripped");
endmodule
bind half_bridge_gate_protection gate_protect_sva u_gate_protect_sva (.clock,
  .reset_n, .cmd_in, .flags_in, .low_gate_en, .high_gate_en, .fault_n_out,
  .fault_n_oe, .cs_ramp_req, .standby_lowpower);

// [tb/flyback_ctrl_model.sv]
`timescale 1ns/1ps
module flyback_ctrl_model (
  input  wire logic clock,
  input  wire logic low_req,
  input  wire logic high_req,
  input  wire logic cs_ramp_req,
  output logic      low_side_cmd = 1'h0,
  output logic      high_side_cmd = 1'h0
);
  // A tripped sense input ends the low pulse early, as a controller does
  logic tripped_q = 1'h0;
  always @(negedge clock) begin
    tripped_q     <= low_req && (tripped_q || cs_ramp_req);
    low_side_cmd  <= low_req && !tripped_q && !cs_ramp_req;
    high_side_cmd <= high_req;
  end
endmodule

// [tb/half_bridge_gate_protection_tb.sv]
`timescale 1ns/1ps
module half_bridge_gate_protection_tb;
  import gate_protect_pkg::*;
  logic        clock = 1'h0;
  logic        reset_n, mode, low_req, high_req, low_side_cmd, high_side_cmd;
  logic        low_gate_en, high_gate_en, fault_n_out, fault_n_oe;
  logic        cs_ramp_req, standby_lowpower;
  logic [4:0]  outs;
  cmd_type     cmd_in;
  flags_type   flags_in;
  int          fails, n_compared, cycles;
  // Mode, low, high, flags; then low, high, fault, standby, ramp
  logic [14:0] rows [18] = '{
    {10'h208, 5'h00}, {10'h308, 5'h10}, {10'h008, 5'h02}, {10'h188, 5'h02},
    {10'h208, 5'h00}, {10'h388, 5'h10}, {10'h248, 5'h00}, {10'h2C8, 5'h00},
    {10'h268, 5'h00}, {10'h368, 5'h10}, {10'h209, 5'h04}, {10'h289, 5'h04},
    {10'h201, 5'h00}, {10'h281, 5'h08}, {10'h218, 5'h00}, {10'h318, 5'h00},
    {10'h20A, 5'h00}, {10'h30A, 5'h10}};
  assign cmd_in = {mode, low_side_cmd, high_side_cmd};
  assign outs = {low_gate_en, high_gate_en, fault_n_oe, standby_lowpower,
                 cs_ramp_req};
  half_bridge_gate_protection u_half_bridge_gate_protection (.clock, .reset_n,
    .cmd_in, .flags_in, .low_gate_en, .high_gate_en, .fault_n_out,
    .fault_n_oe, .cs_ramp_req, .standby_lowpower);
  flyback_ctrl_model u_flyback_ctrl_model (.clock, .low_req, .high_req,
    .cs_ramp_req, .low_side_cmd, .high_side_cmd);
  task automatic chk(input logic [4:0] exp);
    n_compared++;
    if (outs !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, outs, exp);
    end
  endtask
  task automatic step(input logic [9:0] v, input int n, input logic [4:0] e);
    @(negedge clock);
    {mode, low_req, high_req, flags_in} <= v;
    repeat (n) @(negedge clock);
    chk(e);
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #2.5 clock = ~clock;
  // Tests take some 306 cycles; a hang stops here
  always @(posedge clock)
    if (++cycles == 2000) begin
      fails++;
      wrap_up();
    end
  initial begin
    {reset_n, mode, low_req, high_req, flags_in} = 11'h008;
    repeat (3) @(negedge clock);
    reset_n <= 1'h1;
    foreach (rows[i]) begin
      step(rows[i][14:5], 8, rows[i][4:0]);
    end
    step(10'h208, 8, 5'h00);
    step(10'h288, 8, 5'h08);
    step(10'h2C8, 8, 5'h08);
    step(10'h2E8, 8, 5'h00);
    step(10'h208, 8, 5'h00);
    step(10'h288, 8, 5'h08);
    step(10'h28A, 8, 5'h00);
    step(10'h308, 8, 5'h10);
    step(10'h388, 8, 5'h10);
    step(10'h30C, 4, 5'h01);
    step(10'h30C, 8, 5'h00);
    step(10'h208, 8, 5'h00);
    step(10'h308, 8, 5'h10);
    step(10'h289, 8, 5'h04);
    step(10'h288, 8, 5'h00);
    reset_n <= 1'h0;
    @(negedge clock);
    chk(5'h00);
    reset_n <= 1'h1;
    step(10'h208, 8, 5'h00);
    wrap_up();
  end
endmodule
